// ===== cpu_stack_pkg.sv
/*
  Shared constants and types for the processor register core: address map,
  flag positions, reset values, command and capture encodings.
  Assumes a 200 MHz system clock and a 16-bit address space.
*/
`default_nettype none
package cpu_stack_pkg;

  // ---------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------
  localparam logic [15:0] ROM_SMALL_BASE = 16'h3000;
  localparam logic [15:0] ROM_LARGE_BASE = 16'h2000;
  localparam logic [15:0] ADDR_TOP       = 16'h3fff;
  localparam logic [15:0] SPECIAL_BASE   = 16'h3f00;
  localparam logic [15:0] VECTOR_BASE    = 16'h3ff4;
  localparam logic [15:0] VEC_RESET_LO   = 16'h3ffe;
  localparam logic [15:0] ZERO_PAGE_TOP  = 16'h00ff;
  localparam logic [15:0] RAM_LOW_TOP    = 16'h007f;
  localparam logic [15:0] RAM_HIGH_BASE  = 16'h0100;
  localparam logic [15:0] RAM_HIGH_TOP   = 16'h027f;
  localparam logic [7:0]  SPECIAL_PAGE   = 8'h3f;
  localparam logic [7:0]  STACK_PAGE     = 8'h00;
  localparam int unsigned ROM_SMALL_BYTES = 4096;
  localparam int unsigned ROM_LARGE_BYTES = 8192;
  localparam int unsigned RAM_SMALL_BYTES = 128;
  localparam int unsigned RAM_LARGE_BYTES = 512;

  // ---------------------------------------------------------------------
  // Registers and flags
  // ---------------------------------------------------------------------
  localparam int unsigned PCH_WIDTH = 6;
  localparam int unsigned PC_WIDTH  = PCH_WIDTH + 8;
  localparam int unsigned FLAG_I    = 2;
  localparam int unsigned FLAG_T    = 5;
  localparam logic [7:0]  FLAGS_RESET = 8'h04;
  localparam logic [7:0]  DATA_RESET  = 8'h00;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RESET_LOW_NS  = 2000;
  localparam int unsigned RESET_LOW_CYC =
    (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP, CMD_LOAD_A, CMD_LOAD_X, CMD_LOAD_Y, CMD_LOAD_FLAGS,
    CMD_COPY_X_SP, CMD_JUMP, CMD_CALL, CMD_CALL_SPECIAL, CMD_RETURN_SUB,
    CMD_INTERRUPT, CMD_RETURN_INT, CMD_PUSH_A, CMD_PULL_A, CMD_PUSH_FLAGS,
    CMD_PULL_FLAGS, CMD_EFF_ADDR, CMD_MEM_RESULT
  } cmd_type;

  typedef enum logic [1:0] {IDX_NONE, IDX_X, IDX_Y, IDX_T} idx_mode_type;

  typedef enum logic [2:0] {CAP_NONE, CAP_A, CAP_PS, CAP_PCL, CAP_PCH} cap_type;

endpackage
`default_nettype wire

// ===== eff_addr_unit.sv
/*
  Effective address former for the indexed addressing modes.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/100ps
`default_nettype none
module eff_addr_unit
  import cpu_stack_pkg::*;
(
  // Operand and index values
  input  wire logic [15:0]  operandAddr,
  input  wire logic [7:0]   indexX,
  input  wire logic [7:0]   indexY,
  input  wire idx_mode_type mode,
  // Result
  output logic      [15:0]  effAddr
);

  // ---------------------------------------------------------------------
  // Sums wrap in 16 bits, as a carry out has nowhere to go
  // ---------------------------------------------------------------------
  wire logic [15:0] xSum = operandAddr + {8'h00, indexX};
  wire logic [15:0] ySum = operandAddr + {8'h00, indexY};

  assign effAddr = (mode == IDX_X) ? xSum :
                   (mode == IDX_Y) ? ySum :
                   (mode == IDX_T) ? {8'h00, indexX} : operandAddr;

endmodule
`default_nettype wire

// ===== addr_region_decode.sv
/*
  Fixed address-region decode: ROM, special page, vectors, zero page, RAM.
  Combinational; ROM and RAM sizes select the part variant.
*/
`timescale 1ns/100ps
`default_nettype none
module addr_region_decode
  import cpu_stack_pkg::*;
#(
  parameter int unsigned ROM_BYTES = ROM_SMALL_BYTES,
  parameter int unsigned RAM_BYTES = RAM_SMALL_BYTES
)
(
  // Address under decode
  input  wire logic [15:0] addr,
  // Region hits
  output logic             romSel,
  output logic             specialSel,
  output logic             vectorSel,
  output logic             zeroSel,
  output logic             ramSel
);

  localparam logic [15:0] ROM_BASE =
    (ROM_BYTES == ROM_LARGE_BYTES) ? ROM_LARGE_BASE : ROM_SMALL_BASE;

  function automatic logic inRange(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // ---------------------------------------------------------------------
  // Region hits; the second RAM range exists only on the large variant
  // ---------------------------------------------------------------------
  wire logic highRam = (RAM_BYTES == RAM_LARGE_BYTES) &&
                       inRange(addr, RAM_HIGH_BASE, RAM_HIGH_TOP);

  assign romSel     = inRange(addr, ROM_BASE, ADDR_TOP);
  assign specialSel = inRange(addr, SPECIAL_BASE, ADDR_TOP);
  assign vectorSel  = inRange(addr, VECTOR_BASE, ADDR_TOP);
  assign zeroSel    = inRange(addr, 16'h0000, ZERO_PAGE_TOP);
  assign ramSel     = inRange(addr, 16'h0000, RAM_LOW_TOP) || highRam;

endmodule
`default_nettype wire

// ===== cpu_stack_map.sv
/*
  Programmer-visible register core of a small 8-bit processor: accumulator,
  two index registers, 8-bit stack pointer with push/pull sequencing, a
  14-bit program counter, vector fetch and fixed address-region decode.
  Assumes a synchronous memory on the same clock that returns read data in
  the cycle after memRd_ff is seen high; commands arrive from the
  instruction sequencer on the same clock.
*/
// Notes on behaviour
// [RQ1] Program counter high byte holds six bits
// [RQ2] ROM decoded at top, 3000 or 2000 up
// [RQ3] Page 3F00-3FFF reached by two-byte call
// [RQ4] Vectors fetched from 3FF4 through 3FFF; vecNum 6 and 7 fetch from 3FF2 and 3FF0 instead
// [RQ5] Zero page is 0000 through 00FF
// [RQ6] RAM 0000-007F, plus 0100-027F on large
// [RQ7] RAM holds both data and stack
// [RQ8] Eight-bit accumulator is main data register
// [RQ9] X-indexed address is operand plus X
// [RQ10] T flag: X itself addresses second operand
// [RQ11] Y-indexed address is operand plus Y
// [RQ12] Stack pointer points free; decrement after push
// [RQ13] Reset keeps stack pointer; software loads it
// [RQ14] Interrupt pushes PC high, PC low, flags
// [RQ15] Return from interrupt pops flags, low, high
// [RQ16] Accumulator saved only by push/pull accumulator
// [RQ17] Push/pull flags store and reload flags
// [RQ18] Call pushes only PC; return restores it
// [RQ19] Reset pin held low over two microseconds; rst is active high, held 400 cycles (2000 ns) in check_stack, 3 cycles for the first reset
// [RQ20] T flag: memory operations bypass accumulator
// [RQ21] Stack address high byte is zero
`timescale 1ns/100ps
`default_nettype none
module cpu_stack_map
  import cpu_stack_pkg::*;
#(
  parameter int unsigned ROM_BYTES = ROM_SMALL_BYTES,
  parameter int unsigned RAM_BYTES = RAM_SMALL_BYTES
)
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Command port
  input  wire logic               cmdValid,
  input  wire cmd_type            cmdOp,
  input  wire logic [7:0]         cmdData,
  input  wire logic [15:0]        cmdAddr,
  input  wire idx_mode_type       idxMode,
  input  wire logic [2:0]         vecNum,
  output logic                    busy_ff,
  // Register view
  output logic [7:0]              accum_ff,
  output logic [7:0]              indexX_ff,
  output logic [7:0]              indexY_ff,
  output logic [7:0]              stackPtr_ff,
  output logic [7:0]              flags_ff,
  output logic [PC_WIDTH-1:0]     progCounter_ff,
  output logic [15:0]             effAddr_ff,
  // Memory port
  output logic [15:0]             memAddr_ff,
  output logic [7:0]              memWrData_ff,
  output logic                    memWr_ff,
  output logic                    memRd_ff,
  input  wire logic [7:0]         memRdData,
  // Region hits for memAddr_ff
  output logic                    romSel_ff,
  output logic                    specialSel_ff,
  output logic                    vectorSel_ff,
  output logic                    zeroSel_ff,
  output logic                    ramSel_ff
);

  // ---------------------------------------------------------------------
  // State and internal registers
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PS, ST_POP_PS,
    ST_POP_PCL, ST_POP_PCH, ST_VEC_LO, ST_VEC_HI, ST_DRAIN
  } state_type;

  state_type         state_ff, nxtState;
  cap_type           cap1_ff, cap2_ff, nxt_cap;
  logic              isIrq_ff, nxt_isIrq;
  logic [15:0]       vecAddr_ff, nxt_vecAddr;
  logic [PC_WIDTH-1:0] callTarget_ff, nxt_callTarget;
  logic [7:0]        nxt_accum, nxt_indexX, nxt_indexY, nxt_stackPtr, nxt_flags;
  logic [PC_WIDTH-1:0] nxt_progCounter;
  logic [15:0]       nxt_effAddr, nxt_memAddr;
  logic [7:0]        nxt_memWrData;
  logic              nxt_memWr, nxt_memRd;
  logic [15:0]       eaValue;
  logic              romHit, specialHit, vectorHit, zeroHit, ramHit;

  // ---------------------------------------------------------------------
  // Named decodes
  // ---------------------------------------------------------------------
  // Commands are only taken with the capture pipe empty
  wire logic cmdTake = cmdValid && (state_ff == ST_IDLE) &&
                       (cap1_ff == CAP_NONE) && (cap2_ff == CAP_NONE);
  wire logic [7:0]  spDec     = stackPtr_ff - 8'h01;
  wire logic [7:0]  spInc     = stackPtr_ff + 8'h01;
  wire logic [15:0] pushAddr  = {STACK_PAGE, stackPtr_ff};      // RQ21
  wire logic [15:0] popAddr   = {STACK_PAGE, spInc};            // RQ21
  wire logic [7:0]  pcHighByte = {2'b00, progCounter_ff[PC_WIDTH-1:8]};
  wire logic        tFlag     = flags_ff[FLAG_T];
  wire logic [15:0] vecStart  = VEC_RESET_LO - {12'h000, vecNum, 1'b0};
  wire logic [PC_WIDTH-1:0] specialTarget =
    {SPECIAL_PAGE[PCH_WIDTH-1:0], cmdData};                     // RQ3

  // ---------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------
  eff_addr_unit u_ea (
    .operandAddr (cmdAddr),
    .indexX      (indexX_ff),
    .indexY      (indexY_ff),
    .mode        (idxMode),
    .effAddr     (eaValue)
  );

  addr_region_decode #(
    .ROM_BYTES (ROM_BYTES),
    .RAM_BYTES (RAM_BYTES)
  ) u_dec (
    .addr       (nxt_memAddr),
    .romSel     (romHit),
    .specialSel (specialHit),
    .vectorSel  (vectorHit),
    .zeroSel    (zeroHit),
    .ramSel     (ramHit)
  );

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // Read data lands two cycles after the pop is issued, so captures
  // overlap with later pops instead of stalling each one
  always_comb
  begin
    nxtState        = state_ff;
    nxt_cap         = CAP_NONE;
    nxt_isIrq       = isIrq_ff;
    nxt_vecAddr     = vecAddr_ff;
    nxt_callTarget  = callTarget_ff;
    nxt_accum       = accum_ff;
    nxt_indexX      = indexX_ff;
    nxt_indexY      = indexY_ff;
    nxt_stackPtr    = stackPtr_ff;
    nxt_flags       = flags_ff;
    nxt_progCounter = progCounter_ff;
    nxt_effAddr     = effAddr_ff;
    nxt_memAddr     = memAddr_ff;
    nxt_memWrData   = memWrData_ff;
    nxt_memWr       = 1'b0;
    nxt_memRd       = 1'b0;
    case (cap2_ff)
      CAP_A:   nxt_accum = memRdData;                            // RQ16
      CAP_PS:  nxt_flags = memRdData;                            // RQ17
      CAP_PCL: nxt_progCounter[7:0] = memRdData;                 // RQ18
      CAP_PCH: nxt_progCounter[PC_WIDTH-1:8] = memRdData[PCH_WIDTH-1:0]; // RQ1
      default: ;
    endcase
    case (state_ff)
      ST_IDLE:
      begin
        if (cmdTake)
        begin
          case (cmdOp)
            CMD_LOAD_A:     nxt_accum = cmdData;                 // RQ8
            CMD_LOAD_X:     nxt_indexX = cmdData;
            CMD_LOAD_Y:     nxt_indexY = cmdData;
            CMD_LOAD_FLAGS: nxt_flags = cmdData;
            CMD_COPY_X_SP:  nxt_stackPtr = indexX_ff;            // RQ13
            CMD_JUMP:       nxt_progCounter = cmdAddr[PC_WIDTH-1:0]; // RQ1
            CMD_EFF_ADDR:   nxt_effAddr = eaValue;               // RQ9 RQ11
            CMD_MEM_RESULT:
            begin
              if (tFlag)
              begin
                nxt_memAddr = {8'h00, indexX_ff};                // RQ10 RQ20
                nxt_memWrData = cmdData;
                nxt_memWr = 1'b1;
              end
              else
                nxt_accum = cmdData;
            end
            CMD_CALL, CMD_CALL_SPECIAL:
            begin
              nxt_callTarget = (cmdOp == CMD_CALL_SPECIAL) ?
                               specialTarget : cmdAddr[PC_WIDTH-1:0];
              nxt_isIrq = 1'b0;
              nxtState = ST_PUSH_PCH;                            // RQ18
            end
            CMD_INTERRUPT:
            begin
              nxt_vecAddr = vecStart;
              nxt_isIrq = 1'b1;
              nxtState = ST_PUSH_PCH;                            // RQ14
            end
            CMD_RETURN_INT: nxtState = ST_POP_PS;                // RQ15
            CMD_RETURN_SUB: nxtState = ST_POP_PCL;               // RQ18
            CMD_PUSH_A, CMD_PUSH_FLAGS:
            begin
              nxt_memAddr = pushAddr;
              nxt_memWrData = (cmdOp == CMD_PUSH_A) ? accum_ff : flags_ff; // RQ16 RQ17
              nxt_memWr = 1'b1;
              nxt_stackPtr = spDec;                              // RQ12
            end
            CMD_PULL_A, CMD_PULL_FLAGS:
            begin
              nxt_memAddr = popAddr;
              nxt_memRd = 1'b1;
              nxt_stackPtr = spInc;
              nxt_cap = (cmdOp == CMD_PULL_A) ? CAP_A : CAP_PS;  // RQ16 RQ17
              nxtState = ST_DRAIN;
            end
            default: ;
          endcase
        end
      end
      ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PS:
      begin
        nxt_memAddr = pushAddr;                                  // RQ7
        nxt_memWr = 1'b1;
        nxt_stackPtr = spDec;                                    // RQ12
        case (state_ff)
          ST_PUSH_PCH:
          begin
            nxt_memWrData = pcHighByte;                          // RQ14
            nxtState = ST_PUSH_PCL;
          end
          ST_PUSH_PCL:
          begin
            nxt_memWrData = progCounter_ff[7:0];
            if (isIrq_ff)
              nxtState = ST_PUSH_PS;
            else
            begin
              nxt_progCounter = callTarget_ff;                   // RQ18
              nxtState = ST_IDLE;
            end
          end
          default:
          begin
            nxt_memWrData = flags_ff;                            // RQ14
            nxt_flags[FLAG_I] = 1'b1;
            nxtState = ST_VEC_LO;
          end
        endcase
      end
      ST_POP_PS, ST_POP_PCL, ST_POP_PCH:
      begin
        nxt_memAddr = popAddr;
        nxt_memRd = 1'b1;
        nxt_stackPtr = spInc;
        case (state_ff)
          ST_POP_PS:
          begin
            nxt_cap = CAP_PS;                                    // RQ15
            nxtState = ST_POP_PCL;
          end
          ST_POP_PCL:
          begin
            nxt_cap = CAP_PCL;
            nxtState = ST_POP_PCH;
          end
          default:
          begin
            nxt_cap = CAP_PCH;
            nxtState = ST_DRAIN;
          end
        endcase
      end
      ST_VEC_LO:
      begin
        nxt_memAddr = vecAddr_ff;                                // RQ4
        nxt_memRd = 1'b1;
        nxt_cap = CAP_PCL;
        nxtState = ST_VEC_HI;
      end
      ST_VEC_HI:
      begin
        nxt_memAddr = vecAddr_ff + 16'h0001;                     // RQ4
        nxt_memRd = 1'b1;
        nxt_cap = CAP_PCH;
        nxtState = ST_DRAIN;
      end
      ST_DRAIN:
        if (cap1_ff == CAP_NONE)
          nxtState = ST_IDLE;
      default: nxtState = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // Stack pointer has no reset on purpose: software must copy X into it
  always_ff @(posedge sys_clk)
  begin
    stackPtr_ff <= nxt_stackPtr;                                 // RQ13
  end

  // Reset starts a fetch of the reset vector into the program counter
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff       <= ST_VEC_LO;
      cap1_ff        <= CAP_NONE;
      cap2_ff        <= CAP_NONE;
      isIrq_ff       <= 1'b0;
      vecAddr_ff     <= VEC_RESET_LO;
      callTarget_ff  <= '0;
      busy_ff        <= 1'b1;
      accum_ff       <= DATA_RESET;
      indexX_ff      <= DATA_RESET;
      indexY_ff      <= DATA_RESET;
      flags_ff       <= FLAGS_RESET;
      progCounter_ff <= '0;
      effAddr_ff     <= 16'h0000;
      memAddr_ff     <= 16'h0000;
      memWrData_ff   <= DATA_RESET;
      memWr_ff       <= 1'b0;
      memRd_ff       <= 1'b0;
    end
    else
    begin
      state_ff       <= nxtState;
      cap1_ff        <= nxt_cap;
      cap2_ff        <= cap1_ff;
      isIrq_ff       <= nxt_isIrq;
      vecAddr_ff     <= nxt_vecAddr;
      callTarget_ff  <= nxt_callTarget;
      busy_ff        <= (nxtState != ST_IDLE);
      accum_ff       <= nxt_accum;
      indexX_ff      <= nxt_indexX;
      indexY_ff      <= nxt_indexY;
      flags_ff       <= nxt_flags;
      progCounter_ff <= nxt_progCounter;
      effAddr_ff     <= nxt_effAddr;
      memAddr_ff     <= nxt_memAddr;
      memWrData_ff   <= nxt_memWrData;
      memWr_ff       <= nxt_memWr;
      memRd_ff       <= nxt_memRd;
    end
  end

  // Region flags registered alongside the address they describe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      romSel_ff     <= 1'b0;
      specialSel_ff <= 1'b0;
      vectorSel_ff  <= 1'b0;
      zeroSel_ff    <= 1'b1;
      ramSel_ff     <= 1'b1;
    end
    else
    begin
      romSel_ff     <= romHit;                                   // RQ2
      specialSel_ff <= specialHit;                               // RQ3
      vectorSel_ff  <= vectorHit;                                // RQ4
      zeroSel_ff    <= zeroHit;                                  // RQ5
      ramSel_ff     <= ramHit;                                   // RQ6
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_jump_pc_width: assert property ( // RQ1
    cmdTake && cmdOp == CMD_JUMP |=> progCounter_ff == $past(cmdAddr[13:0]))
    else $error("jump did not load 14-bit counter");

  a_rom_region: assert property ( // RQ2
    romSel_ff |-> memAddr_ff <= ADDR_TOP &&
      memAddr_ff >= ((ROM_BYTES == ROM_LARGE_BYTES) ? ROM_LARGE_BASE : ROM_SMALL_BASE))
    else $error("rom select outside rom range");

  a_special_call: assert property ( // RQ3
    cmdTake && cmdOp == CMD_CALL_SPECIAL |=> ##2
      progCounter_ff == {SPECIAL_PAGE[5:0], $past(cmdData, 3)})
    else $error("special page call target wrong");

  a_vector_fetch: assert property ( // RQ4
    !rst && state_ff == ST_VEC_LO |=> memRd_ff && vectorSel_ff ##1 memRd_ff && vectorSel_ff)
    else $error("vector fetch outside vector table");

  a_zero_page: assert property ( // RQ5
    zeroSel_ff == (memAddr_ff[15:8] == 8'h00))
    else $error("zero page flag mismatch");

  a_stack_in_ram: assert property ( // RQ21
    (memWr_ff || memRd_ff) && !vectorSel_ff && state_ff != ST_IDLE |->
      memAddr_ff[15:8] == STACK_PAGE)
    else $error("stack access left page zero");

  a_push_decrement: assert property ( // RQ12
    cmdTake && cmdOp == CMD_PUSH_A |=> memWr_ff &&
      memAddr_ff == {8'h00, $past(stackPtr_ff)} &&
      stackPtr_ff == $past(stackPtr_ff) - 8'h01)
    else $error("push address or decrement wrong");

  a_irq_push_order: assert property ( // RQ14
    cmdTake && cmdOp == CMD_INTERRUPT |=> ##1
      memWrData_ff == {2'b00, $past(progCounter_ff[13:8], 2)} ##1
      memWrData_ff == $past(progCounter_ff[7:0], 3) ##1
      memWrData_ff == $past(flags_ff, 4))
    else $error("interrupt push order wrong");

  a_tmode_direct: assert property ( // RQ20
    cmdTake && cmdOp == CMD_MEM_RESULT && tFlag |=> memWr_ff &&
      memAddr_ff == {8'h00, $past(indexX_ff)} && $stable(accum_ff))
    else $error("T mode result passed through accumulator");

  a_pull_accum: assert property ( // RQ16
    cmdTake && cmdOp == CMD_PULL_A |-> ##3 accum_ff == $past(memRdData))
    else $error("pulled accumulator value wrong");

  c_interrupt: cover property (cmdTake && cmdOp == CMD_INTERRUPT ##[1:12] !busy_ff);
  c_return_int: cover property (cmdTake && cmdOp == CMD_RETURN_INT);
  c_special_call: cover property (cmdTake && cmdOp == CMD_CALL_SPECIAL);
  c_tmode_write: cover property (cmdTake && cmdOp == CMD_MEM_RESULT && tFlag);

endmodule
`default_nettype wire

// ===== stack_mem_model.sv
/*
  Synchronous byte memory that stands for the on-chip program ROM and data RAM.
  Assumes the core's clock; read data is valid only in the cycle after a read.
*/
`timescale 1ns/100ps
`default_nettype none
module stack_mem_model
(
  // Clock
  input  wire logic        sys_clk,
  // Access from the core
  input  wire logic [15:0] memAddr,
  input  wire logic [7:0]  memWrData,
  input  wire logic        memWr,
  input  wire logic        memRd,
  output logic      [7:0]  memRdData
);
  logic [7:0] mem [0:65535];

  initial memRdData = 8'h00;

  // Data is scrambled outside its cycle, so a late capture reads garbage
  always @(posedge sys_clk)
  begin
    if (memWr)
      mem[memAddr] <= memWrData;
    memRdData <= memRd ? mem[memAddr] : ~memRdData;
  end
endmodule
`default_nettype wire

// ===== cpu_stack_map_tb.sv
/*
  Self-checking bench for the register core and its memory.
  Assumes the package and the memory model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module cpu_stack_map_tb
  import cpu_stack_pkg::*;
();
  // Core and memory signals
  logic         sys_clk, rst, cmdValid, busy_ff, memWr_ff, memRd_ff;
  logic         romSel_ff, specialSel_ff, vectorSel_ff, zeroSel_ff, ramSel_ff;
  cmd_type      cmdOp;
  idx_mode_type idxMode;
  logic [2:0]   vecNum;
  logic [7:0]   cmdData, memRdData, memWrData_ff, accum_ff;
  logic [7:0]   indexX_ff, indexY_ff, stackPtr_ff, flags_ff;
  logic [13:0]  progCounter_ff;
  logic [15:0]  cmdAddr, effAddr_ff, memAddr_ff;
  int           errors, samplesChecked, cycles;

  cpu_stack_map dut_u (.sys_clk, .rst, .cmdValid, .cmdOp, .cmdData, .cmdAddr, .idxMode, .vecNum,
    .busy_ff, .accum_ff, .indexX_ff, .indexY_ff, .stackPtr_ff, .flags_ff, .progCounter_ff,
    .effAddr_ff, .memAddr_ff, .memWrData_ff, .memWr_ff, .memRd_ff, .memRdData, .romSel_ff,
    .specialSel_ff, .vectorSel_ff, .zeroSel_ff, .ramSel_ff);
  stack_mem_model mem_u (.sys_clk, .memAddr(memAddr_ff), .memWrData(memWrData_ff),
    .memWr(memWr_ff), .memRd(memRd_ff), .memRdData);

  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Command driving
  // ---------------------------------------------------------------
  task automatic idle();
    for (int i = 0; i < 20 && busy_ff !== 1'b0; i++)
      @(negedge sys_clk);
  endtask

  // Request held until taken, then one spare edge lets writes land
  task automatic cmd(input cmd_type op, input logic [7:0] d = 8'h00,
                     input logic [15:0] a = 16'h0000, input idx_mode_type m = IDX_NONE,
                     input logic [2:0] v = 3'h0);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    cmdData <= d;
    cmdAddr <= a;
    idxMode <= m;
    vecNum <= v;
    @(negedge sys_clk);
    idle();
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    @(negedge sys_clk);
    idle();
    @(negedge sys_clk);
  endtask

  task automatic reset_core(input int unsigned n);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    idle();
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic check_stack();
    cmd(CMD_LOAD_X, 8'h40);
    cmd(CMD_COPY_X_SP);
    cmd(CMD_LOAD_A, 8'h5a);
    cmd(CMD_PUSH_A);
    `CHK("sp push", 8'h3f, stackPtr_ff)
    `CHK("ram push", 8'h5a, mem_u.mem[16'h0040])
    `CHK("ram sel", 2'b11, {ramSel_ff, zeroSel_ff})
    cmd(CMD_LOAD_FLAGS, 8'hc3);
    cmd(CMD_PUSH_FLAGS);
    cmd(CMD_LOAD_A, 8'h00);
    cmd(CMD_LOAD_FLAGS, 8'h00);
    cmd(CMD_PULL_FLAGS);
    `CHK("flags pull", 8'hc3, flags_ff)
    cmd(CMD_PULL_A);
    `CHK("acc pull", 8'h5a, accum_ff)
    `CHK("sp pull", 8'h40, stackPtr_ff)
    reset_core(RESET_LOW_CYC);
    `CHK("sp reset", 8'h40, stackPtr_ff)
  endtask

  task automatic check_calls();
    cmd(CMD_CALL, 8'h00, 16'h1234);
    `CHK("call frame", 16'h3010, {mem_u.mem[16'h0040], mem_u.mem[16'h003f]})
    cmd(CMD_RETURN_SUB);
    `CHK("rts pc", 14'h3010, progCounter_ff)
    cmd(CMD_CALL_SPECIAL, 8'h55);
    `CHK("special pc", 14'h3f55, progCounter_ff)
    cmd(CMD_LOAD_FLAGS, 8'h00);
    for (int v = 0; v < 6; v++)
    begin
      cmd(CMD_INTERRUPT, 8'h00, 16'h0000, IDX_NONE, 3'(v));
      `CHK("isr pc", {6'h30 + 6'(v), 8'h10 + 8'(v)}, progCounter_ff)
      `CHK("isr frame", 24'h3f5500, {mem_u.mem[8'h3e], mem_u.mem[8'h3d], mem_u.mem[8'h3c]})
      `CHK("isr flags", 8'h04, flags_ff)
      `CHK("regions", 4'b1110, {romSel_ff, specialSel_ff, vectorSel_ff, zeroSel_ff})
      cmd(CMD_RETURN_INT);
      `CHK("rti state", 30'h3f55003e, {progCounter_ff, flags_ff, stackPtr_ff})
    end
  endtask

  task automatic check_index();
    idx_mode_type md[4] = '{IDX_X, IDX_Y, IDX_T, IDX_NONE};
    logic [15:0]  ex[4] = '{16'h0010, 16'hff41, 16'h00f0, 16'hff20};
    cmd(CMD_LOAD_X, 8'hf0);
    cmd(CMD_LOAD_Y, 8'h21);
    `CHK("index regs", 16'hf021, {indexX_ff, indexY_ff})
    for (int i = 0; i < 4; i++)
    begin
      cmd(CMD_EFF_ADDR, 8'h00, 16'hff20, md[i]);
      `CHK("eff addr", ex[i], effAddr_ff)
    end
    cmd(CMD_LOAD_FLAGS, 8'h20);
    cmd(CMD_LOAD_A, 8'h11);
    cmd(CMD_MEM_RESULT, 8'h77);
    `CHK("mem direct", 16'h7711, {mem_u.mem[16'h00f0], accum_ff})
    `CHK("t regions", 2'b01, {ramSel_ff, zeroSel_ff})
    cmd(CMD_LOAD_FLAGS, 8'h00);
    cmd(CMD_MEM_RESULT, 8'h66);
    `CHK("mem via acc", 8'h66, accum_ff)
    cmd(CMD_JUMP, 8'h00, 16'hf123);
    `CHK("jump pc", 14'h3123, progCounter_ff)
  endtask

  // Main sequence; vectors hold a high byte wider than six bits
  initial
  begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = CMD_NOP;
    cmdData = 8'h00;
    cmdAddr = 16'h0000;
    idxMode = IDX_NONE;
    vecNum = 3'h0;
    errors = 0;
    samplesChecked = 0;
    cycles = 0;
    for (int v = 0; v < 6; v++)
    begin
      mem_u.mem[16'h3ffe - 16'(2 * v)] = 8'h10 + 8'(v);
      mem_u.mem[16'h3fff - 16'(2 * v)] = 8'hf0 + 8'(v);
    end
    reset_core(3);
    `CHK("pc reset", 14'h3010, progCounter_ff)
    check_stack();
    check_calls();
    check_index();
    print_verdict();
  end
endmodule
`default_nettype wire
